// ---- include/pwc_pkg.sv ----
// pwc_pkg: register offsets, field positions, reset values and codes for the pwm channel
// assumes byte-wide registers, each on its own aligned 32-bit apb word
package pwc_pkg;

  // register byte addresses
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_CNT_HI = 8'h0C;
  localparam logic [7:0] OFF_DUTY_LO = 8'h10;
  localparam logic [7:0] OFF_DUTY_HI = 8'h14;
  localparam logic [7:0] OFF_PER_LO = 8'h18;
  localparam logic [7:0] OFF_PER_HI = 8'h1C;

  // field positions
  localparam int CS_LSB = 0;
  localparam int IS_LSB = 2;
  localparam int NEG_BIT = 4;
  localparam int RUN_BIT = 0;
  localparam int SPARE_LSB = 1;
  localparam int FLAG_BIT = 6;
  localparam int STAT_BIT = 7;

  // reset values
  localparam logic [4:0] CTRL0_RST = 5'h00;
  localparam logic [4:0] SPARE_RST = 5'h00;
  localparam logic RUN_RST = 1'b0;
  localparam logic FLAG_RST = 1'b1;
  localparam logic STAT_RST = 1'b0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'h0000;

  // interrupt point code for duty match only
  localparam logic [1:0] IS_DUTY = 2'b01;

  // count clock choices
  typedef enum logic [1:0] {
    PWC_CS_LOW = 2'b00,
    PWC_CS_HTB = 2'b01,
    PWC_CS_OFF = 2'b10,
    PWC_CS_EXT = 2'b11
  } pwc_clk_sel_t;

  // replace one byte of a 16-bit value
  function automatic logic [15:0] pwc_put_byte(input logic [15:0] w, input logic hi,
                                               input logic [7:0] b);
    return hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction : pwc_put_byte

endpackage : pwc_pkg

// ---- verilog/pwc_clk_sel.sv ----
// pwc_clk_sel: picks the count clock and marks each of its falling edges
// assumes all clock inputs are already synchronous to pclk
`timescale 1ns/10ps
module pwc_clk_sel (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // selection
  input wire logic [1:0] clk_sel,
  // candidate count clocks
  input wire logic low_speed_clock,
  input wire logic high_speed_timebase_clock,
  input wire logic ext_count_clock,
  // one-cycle pulse per falling edge
  output logic fall_tick
);

  logic cur_q;
  logic cur_d;
  logic prev_q;

  // R18: clock choice
  always_comb begin
    case (pwc_pkg::pwc_clk_sel_t'(clk_sel))
      pwc_pkg::PWC_CS_LOW: cur_d = low_speed_clock;
      pwc_pkg::PWC_CS_HTB: cur_d = high_speed_timebase_clock;
      pwc_pkg::PWC_CS_EXT: cur_d = ext_count_clock;
      default: cur_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      cur_q <= cur_d;
      prev_q <= cur_q;
    end
  end

  // R18: prohibited code stops all edges
  assign fall_tick = prev_q && !cur_q && (clk_sel != pwc_pkg::PWC_CS_OFF);

endmodule : pwc_clk_sel

// ---- verilog/pwc_reload.sv ----
// pwc_reload: duty and period registers with their buffers
// assumes one-cycle write strobes and a one-cycle reload pulse
`timescale 1ns/10ps
module pwc_reload (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register writes
  input wire logic wr_duty_lo,
  input wire logic wr_duty_hi,
  input wire logic wr_per_lo,
  input wire logic wr_per_hi,
  input wire logic [7:0] wr_byte,
  // control
  input wire logic stopped,
  input wire logic reload,
  // values
  output logic [15:0] duty_q,
  output logic [15:0] period_q,
  output logic [15:0] duty_buf_q,
  output logic [15:0] period_buf_q
);

  logic [15:0] duty_d;
  logic [15:0] period_d;
  logic duty_wr;
  logic per_wr;

  assign duty_wr = wr_duty_lo || wr_duty_hi;
  assign per_wr = wr_per_lo || wr_per_hi;
  assign duty_d = duty_wr ? pwc_pkg::pwc_put_byte(duty_q, wr_duty_hi, wr_byte) : duty_q;
  assign period_d = per_wr ? pwc_pkg::pwc_put_byte(period_q, wr_per_hi, wr_byte) : period_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_q <= pwc_pkg::DUTY_RST;
      period_q <= pwc_pkg::PER_RST;
    end else begin
      duty_q <= duty_d;
      period_q <= period_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_buf_q <= pwc_pkg::DUTY_RST;
      period_buf_q <= pwc_pkg::PER_RST;
    end else if (stopped) begin
      // R12: stopped writes pass straight through
      if (duty_wr) begin
        duty_buf_q <= duty_d;
      end
      if (per_wr) begin
        period_buf_q <= period_d;
      end
    end else if (reload) begin
      // R8: copy at period match
      duty_buf_q <= duty_q;
      period_buf_q <= period_q;
    end
  end

endmodule : pwc_reload

// ---- verilog/pwc_top.sv ----
// pwc_top: one pwm channel with a 16-bit counter, apb register slave and pwm pin
// assumes count clocks synchronous to pclk and slower than pclk/2
//
// What this block does
// R1: run bit starts and stops counting
// R2: control bit 6 reads the output flag
// R3: counter write sets output flag to 1
// R4: status bit 7 shows counting in progress
// R5: status on first edge, counting from second
// R6: duty match clears flag next edge
// R7: period match sets flag, counter to zero
// R8: period match reloads duty and period buffers
// R9: stop counts one more edge, then status 0
// R10: restart continues from retained count
// R11: any counter byte write zeroes counter
// R12: stopped writes go straight to buffers
// R13: period is setting+1, duty is setting+1
// R14: software keeps period 1..FFF, duty below
// R15: first interrupt late, later ones periodic
// R16: interrupt possible in the final counted edge
// R17: software polls status before treating stopped
// R18: clock select picks clock, code 10 idle
// R19: interrupt point select period, duty, or both
// R20: polarity bit picks positive or negative logic
// R21: low byte read latches the high byte
// R22: pin shows flag, inverted in negative logic
`timescale 1ns/10ps
module pwc_top (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count clock sources
  input wire logic low_speed_clock,
  input wire logic high_speed_timebase_clock,
  input wire logic ext_count_clock,
  // channel outputs
  output logic pwm_out,
  output logic pwm_interrupt
);

  logic [4:0] ctrl0_q;
  logic run_q;
  logic [4:0] spare_q;
  logic stat_q;
  logic flag_q;
  logic [15:0] cnt_q;
  logic [7:0] cnt_hi_latch_q;
  logic irq_q;
  logic pwm_out_q;
  logic [31:0] prdata_q;
  logic [7:0] rd_byte;
  logic mapped;
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic cnt_wr;
  logic tick;
  logic step;
  logic per_hit;
  logic duty_hit;
  logic reload;
  logic [1:0] ctrl_cs;
  logic [1:0] ctrl_is;
  logic ctrl_neg;
  logic [15:0] duty_q;
  logic [15:0] period_q;
  logic [15:0] duty_buf_q;
  logic [15:0] period_buf_q;

  // apb decode
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= pwc_pkg::OFF_PER_HI);
  assign wr = acc && pwrite && mapped;
  assign rd = setup && !pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_q;

  assign ctrl_cs = ctrl0_q[pwc_pkg::CS_LSB +: 2];
  assign ctrl_is = ctrl0_q[pwc_pkg::IS_LSB +: 2];
  assign ctrl_neg = ctrl0_q[pwc_pkg::NEG_BIT];

  // R3: either counter byte written
  assign cnt_wr = wr && (paddr == pwc_pkg::OFF_CNT_LO || paddr == pwc_pkg::OFF_CNT_HI);

  pwc_clk_sel u_clk_sel (
    .pclk(pclk),
    .presetn(presetn),
    .clk_sel(ctrl_cs),
    .low_speed_clock(low_speed_clock),
    .high_speed_timebase_clock(high_speed_timebase_clock),
    .ext_count_clock(ext_count_clock),
    .fall_tick(tick)
  );

  // R14: compares assume duty below period
  assign per_hit = (cnt_q == period_buf_q);
  assign duty_hit = (cnt_q == duty_buf_q);
  assign step = tick && stat_q && !cnt_wr;
  assign reload = step && per_hit;

  pwc_reload u_reload (
    .pclk(pclk),
    .presetn(presetn),
    .wr_duty_lo(wr && paddr == pwc_pkg::OFF_DUTY_LO),
    .wr_duty_hi(wr && paddr == pwc_pkg::OFF_DUTY_HI),
    .wr_per_lo(wr && paddr == pwc_pkg::OFF_PER_LO),
    .wr_per_hi(wr && paddr == pwc_pkg::OFF_PER_HI),
    .wr_byte(pwdata[7:0]),
    .stopped(!stat_q),
    .reload(reload),
    .duty_q(duty_q),
    .period_q(period_q),
    .duty_buf_q(duty_buf_q),
    .period_buf_q(period_buf_q)
  );

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= pwc_pkg::CTRL0_RST;
      run_q <= pwc_pkg::RUN_RST;
      spare_q <= pwc_pkg::SPARE_RST;
    end else if (wr && paddr == pwc_pkg::OFF_CTRL0) begin
      ctrl0_q <= pwdata[4:0];
    end else if (wr && paddr == pwc_pkg::OFF_CTRL1) begin
      // R1: run bit
      run_q <= pwdata[pwc_pkg::RUN_BIT];
      spare_q <= pwdata[pwc_pkg::SPARE_LSB +: 5];
    end
  end

  // status follows run at each falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= pwc_pkg::STAT_RST;
    end else if (tick) begin
      // R5: first edge raises status
      // R9: last counted edge drops it
      // R17: software sees stop only here
      stat_q <= run_q;
    end
  end

  // counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= pwc_pkg::CNT_RST;
    end else if (cnt_wr) begin
      // R11: any write zeroes counter
      cnt_q <= pwc_pkg::CNT_RST;
    end else if (step) begin
      // R7: wrap at period match
      // R13: counts 0..period inclusive
      // R10: otherwise continue from held value
      cnt_q <= per_hit ? pwc_pkg::CNT_RST : cnt_q + 16'h0001;
    end
  end

  // output flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= pwc_pkg::FLAG_RST;
    end else if (cnt_wr) begin
      // R3: counter write sets flag
      flag_q <= 1'b1;
    end else if (step) begin
      // R7: period match sets flag
      // R6: duty match clears flag
      if (per_hit) begin
        flag_q <= 1'b1;
      end else if (duty_hit) begin
        flag_q <= 1'b0;
      end
    end
  end

  // interrupt pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      // R19: interrupt point select
      // R15: matches are on the count clock grid
      // R16: final counted edge may still fire
      irq_q <= step && ((per_hit && ctrl_is != pwc_pkg::IS_DUTY) ||
                        (duty_hit && (ctrl_is == pwc_pkg::IS_DUTY || ctrl_is[1])));
    end
  end
  assign pwm_interrupt = irq_q;

  // pin output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out_q <= pwc_pkg::FLAG_RST;
    end else begin
      // R20: polarity choice
      // R22: flag or its inverse
      pwm_out_q <= flag_q ^ ctrl_neg;
    end
  end
  assign pwm_out = pwm_out_q;

  // high byte latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_hi_latch_q <= 8'h00;
    end else if (rd && paddr == pwc_pkg::OFF_CNT_LO) begin
      // R21: latch on the edge that captures the low byte
      cnt_hi_latch_q <= cnt_q[15:8];
    end
  end

  // read mux
  always_comb begin
    case (paddr)
      pwc_pkg::OFF_CTRL0: rd_byte = {3'h0, ctrl0_q};
      // R2: flag readback
      // R4: status readback
      pwc_pkg::OFF_CTRL1: rd_byte = {stat_q, flag_q, spare_q, run_q};
      pwc_pkg::OFF_CNT_LO: rd_byte = cnt_q[7:0];
      pwc_pkg::OFF_CNT_HI: rd_byte = cnt_hi_latch_q;
      pwc_pkg::OFF_DUTY_LO: rd_byte = duty_q[7:0];
      pwc_pkg::OFF_DUTY_HI: rd_byte = duty_q[15:8];
      pwc_pkg::OFF_PER_LO: rd_byte = period_q[7:0];
      pwc_pkg::OFF_PER_HI: rd_byte = period_q[15:8];
      default: rd_byte = 8'h00;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata_q <= mapped ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cnt_write_clear: assert property (cnt_wr |=> cnt_q == 16'h0000 && flag_q) // R11
    else $error("counter write did not clear counter and set flag");

  a_start_status: assert property (tick && run_q && !stat_q && !cnt_wr
                                   |=> stat_q && $stable(cnt_q)) // R5
    else $error("start edge changed counter or left status low");

  a_stop_status: assert property (tick && !run_q |=> !stat_q) // R9
    else $error("status still high after stop edge");

  a_duty_clear: assert property (step && duty_hit && !per_hit |=> !flag_q) // R6
    else $error("duty match did not clear flag");

  a_period_wrap: assert property (step && per_hit |=> cnt_q == 16'h0000 && flag_q) // R7
    else $error("period match did not wrap counter");

  a_buffer_reload: assert property (reload |=> duty_buf_q == $past(duty_q) &&
                                    period_buf_q == $past(period_q)) // R8
    else $error("buffers not reloaded at period match");

  a_count_step: assert property (step && !per_hit |=> cnt_q == $past(cnt_q) + 16'h0001) // R10
    else $error("counter did not advance by one");

  a_held_count: assert property (!stat_q && !cnt_wr && !tick |=> $stable(cnt_q)) // R1
    else $error("counter moved while stopped");

  a_stopped_write: assert property (wr && paddr == pwc_pkg::OFF_DUTY_LO && !stat_q
                                    |=> duty_buf_q[7:0] == $past(pwdata[7:0])) // R12
    else $error("stopped duty write did not reach buffer");

  a_irq_cause: assert property (pwm_interrupt |-> $past(step && (per_hit || duty_hit))) // R19
    else $error("interrupt without a match");

  a_irq_period: assert property (step && per_hit && ctrl_is != pwc_pkg::IS_DUTY
                                 |=> pwm_interrupt) // R19
    else $error("period match raised no interrupt");

  a_irq_duty_only: assert property (step && per_hit && !duty_hit &&
                                    ctrl_is == pwc_pkg::IS_DUTY |=> !pwm_interrupt) // R19
    else $error("period interrupt raised in duty-only mode");

  a_pin_polarity: assert property (##1 pwm_out == ($past(flag_q) ^ $past(ctrl_neg))) // R22
    else $error("pin does not follow flag and polarity");

  a_hi_latch: assert property (rd && paddr == pwc_pkg::OFF_CNT_LO
                               |=> cnt_hi_latch_q == $past(cnt_q[15:8])) // R21
    else $error("high byte not latched on low read");

  a_idle_clock: assert property (ctrl_cs == pwc_pkg::PWC_CS_OFF |-> !tick) // R18
    else $error("count edge with prohibited clock select");

  c_period_reload: cover property (reload ##[1:1000] reload);
  c_duty_irq: cover property (step && duty_hit && ctrl_is == pwc_pkg::IS_DUTY);
  c_stop_seq: cover property (stat_q && !run_q ##[1:1000] !stat_q);
  c_neg_pin: cover property (ctrl_neg && pwm_out);

endmodule : pwc_top

// ---- test/pwc_load.sv ----
// pwc_load: load on the pwm pin, measures high time and period in pclk cycles
// assumes the pin level is synchronous to pclk
`timescale 1ns/10ps
module pwc_load (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pwm pin
  input wire logic pwm_out,
  // measured lengths
  output logic [15:0] high_len_q,
  output logic [15:0] per_len_q
);
  logic [15:0] age_q;
  logic last_q;
  // period and high time of pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 16'h0000;
      last_q <= 1'b1;
      high_len_q <= 16'h0000;
      per_len_q <= 16'h0000;
    end else begin
      last_q <= pwm_out;
      age_q <= (pwm_out && !last_q) ? 16'h0001 : age_q + 16'h0001;
      if (pwm_out && !last_q) per_len_q <= age_q;
      if (!pwm_out && last_q) high_len_q <= age_q;
    end
  end
endmodule : pwc_load

// ---- test/tb_top.sv ----
// tb_top: register and waveform checks of the pwm channel
// assumes count clocks made here, synchronous to pclk
`timescale 1ns/10ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic lsc, htb, ext, pwm_out, pwm_interrupt;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] high_len, per_len;
  int cyc, fail_count, tests_run;
  pwc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_speed_clock(lsc),
    .high_speed_timebase_clock(htb), .ext_count_clock(ext),
    .pwm_out(pwm_out), .pwm_interrupt(pwm_interrupt));
  pwc_load load (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out),
    .high_len_q(high_len), .per_len_q(per_len));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // count clocks of 8, 4 and 6 pclk periods
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    lsc <= (cyc % 8) < 4;
    htb <= (cyc % 4) < 2;
    ext <= (cyc % 6) < 3;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic give_up();
    fail_count++;
    report_and_stop();
  endtask : give_up
  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask : cycles
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 8'h00);
    chk(what, e, rd);
  endtask : rchk
  task automatic poll_stat(input logic e);
    int n;
    n = 0;
    do begin
      apb(1'b0, pwc_pkg::OFF_CTRL1, 8'h00);
      n++;
    end while (rd[7] !== e && n < 40);
    if (rd[7] !== e) give_up();
  endtask : poll_stat
  task automatic wait_pin(input logic e);
    int n;
    n = 0;
    while (pwm_out !== e && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (pwm_out !== e) give_up();
  endtask : wait_pin
  task automatic restart(input logic [7:0] c0);
    apb(1'b1, pwc_pkg::OFF_CTRL1, 8'h00);
    poll_stat(1'b0);
    apb(1'b1, pwc_pkg::OFF_CNT_LO, 8'h00);
    apb(1'b1, pwc_pkg::OFF_CTRL0, c0);
    apb(1'b1, pwc_pkg::OFF_CTRL1, 8'h01);
  endtask : restart
  task automatic stop_at_fall();
    wait_pin(1'b1);
    wait_pin(1'b0);
    apb(1'b1, pwc_pkg::OFF_CTRL1, 8'h00);
    poll_stat(1'b0);
  endtask : stop_at_fall
  task automatic t_reset();
    rchk(pwc_pkg::OFF_CTRL0, 32'h00, "ctrl0 reset");
    rchk(pwc_pkg::OFF_CTRL1, 32'h40, "ctrl1 reset");
    rchk(pwc_pkg::OFF_CNT_LO, 32'h00, "count reset");
    apb(1'b0, 8'h22, 8'h00);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset
  task automatic t_clock_sel();
    logic [7:0] cs [3] = '{8'h00, 8'h01, 8'h03};
    int tk [3] = '{8, 4, 6};
    // period 3 with duty 1 below it
    apb(1'b1, pwc_pkg::OFF_DUTY_LO, 8'h01);
    apb(1'b1, pwc_pkg::OFF_PER_LO, 8'h03);
    for (int i = 0; i < 3; i++) begin
      restart(cs[i]);
      cycles(200);
      chk("period", 32'(4 * tk[i]), 32'(per_len));
      chk("high", 32'(2 * tk[i]), 32'(high_len));
      apb(1'b0, pwc_pkg::OFF_CTRL1, 8'h00);
      chk("status", 32'h1, 32'(rd[7]));
    end
    $display("test clock select done");
  endtask : t_clock_sel
  task automatic t_irq();
    int ev [3] = '{4, 4, 8};
    int n;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, pwc_pkg::OFF_CTRL0, 8'(i << 2));
      cycles(100);
      n = 0;
      repeat (128) begin
        @(posedge pclk);
        if (pwm_interrupt === 1'b1) n++;
      end
      chk("irq count", 32'(ev[i]), 32'(n));
    end
    $display("test irq select done");
  endtask : t_irq
  task automatic t_stop_clear();
    stop_at_fall();
    rchk(pwc_pkg::OFF_CTRL1, 32'h00, "ctrl1 stopped");
    rchk(pwc_pkg::OFF_CNT_LO, 32'h03, "count stop");
    cycles(50);
    rchk(pwc_pkg::OFF_CNT_LO, 32'h03, "count held");
    apb(1'b1, pwc_pkg::OFF_CTRL1, 8'h01);
    cycles(24);
    chk("resume pin", 32'h1, 32'(pwm_out));
    stop_at_fall();
    apb(1'b1, pwc_pkg::OFF_CNT_HI, 8'hA5);
    rchk(pwc_pkg::OFF_CTRL1, 32'h40, "flag set");
    rchk(pwc_pkg::OFF_CNT_LO, 32'h00, "count lo");
    rchk(pwc_pkg::OFF_CNT_HI, 32'h00, "count hi");
    apb(1'b1, pwc_pkg::OFF_CTRL0, 8'h10);
    cycles(4);
    chk("neg pin", 32'h0, 32'(pwm_out));
    apb(1'b1, pwc_pkg::OFF_CTRL0, 8'h00);
    cycles(4);
    chk("pos pin", 32'h1, 32'(pwm_out));
    $display("test stop and clear done");
  endtask : t_stop_clear
  task automatic t_idle_and_reload();
    restart(8'h02);
    cycles(100);
    rchk(pwc_pkg::OFF_CTRL1, 32'h41, "idle code");
    rchk(pwc_pkg::OFF_CNT_LO, 32'h00, "idle count");
    restart(8'h00);
    cycles(100);
    apb(1'b1, pwc_pkg::OFF_PER_LO, 8'h07);
    cycles(300);
    chk("reload period", 32'd64, 32'(per_len));
    chk("reload high", 32'd16, 32'(high_len));
    // period 207h lets the count pass FFh
    apb(1'b1, pwc_pkg::OFF_PER_HI, 8'h02);
    cycles(2150);
    apb(1'b1, pwc_pkg::OFF_CTRL1, 8'h00);
    poll_stat(1'b0);
    apb(1'b0, pwc_pkg::OFF_CNT_LO, 8'h00);
    rchk(pwc_pkg::OFF_CNT_HI, 32'h01, "latched hi");
    $display("test idle and reload done");
  endtask : t_idle_and_reload
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    fail_count = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_clock_sel();
    t_irq();
    t_stop_clear();
    t_idle_and_reload();
    report_and_stop();
  end
endmodule : tb_top
